// >>> inc/eqctl_defs.vh
/*
 * constants of the equalizer control logic: register offsets, field
 * positions, reset values and threshold tables.
 * assumes inclusion by bare name from the logic files.
 */
`ifndef EQCTL_DEFS_VH
`define EQCTL_DEFS_VH

// register offsets
`define EQC_ADDR_STAT0      8'h00
`define EQC_ADDR_STAT1      8'h01
`define EQC_ADDR_STAT2      8'h02
`define EQC_ADDR_BOOST_A    8'h03
`define EQC_ADDR_BOOST_B    8'h04
`define EQC_ADDR_ON_THR     8'h05
`define EQC_ADDR_OFF_THR    8'h06
`define EQC_ADDR_EN_SRC     8'h07
`define EQC_ADDR_SWING      8'h08

// reset values
`define EQC_RST_BOOST_A     8'h77
`define EQC_RST_BOOST_B     8'h77
`define EQC_RST_THR         2'h0
`define EQC_RST_EN_SRC      1'h0
`define EQC_RST_SWING       2'h2

// field positions
`define EQC_HI_EN_BIT       7
`define EQC_HI_BOOST_MSB    6
`define EQC_HI_BOOST_LSB    4
`define EQC_LO_EN_BIT       3
`define EQC_LO_BOOST_MSB    2
`define EQC_LO_BOOST_LSB    0
`define EQC_SWING_MSB       3
`define EQC_SWING_LSB       2
`define EQC_THR_MSB         1
`define EQC_THR_LSB         0
`define EQC_EN_SRC_BIT      0
`define EQC_PRES_BIT        0
`define EQC_REV_MSB         7
`define EQC_REV_LSB         4

// boost code extremes
`define EQC_BOOST_MIN       3'h0
`define EQC_BOOST_MAX       3'h7

// presence thresholds in millivolts peak-to-peak
`define EQC_ON_MV_00        8'h46
`define EQC_ON_MV_01        8'h37
`define EQC_ON_MV_10        8'h5A
`define EQC_ON_MV_11        8'h4B
`define EQC_OFF_MV_00       8'h28
`define EQC_OFF_MV_01       8'h1E
`define EQC_OFF_MV_10       8'h37
`define EQC_OFF_MV_11       8'h2D

// misc
`define EQC_ZERO_BYTE       8'h00
`define EQC_REV_DEFAULT     4'h1

`endif

// >>> logic/eqctl_presence.v
/*
 * clock-channel presence flag with hysteresis between the on and off
 * thresholds; the amplitude comes in as a millivolt figure.
 * assumes the amplitude measurement is synchronous to the clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "eqctl_defs.vh"

module eqctl_presence (
	input  wire       clk_i,
	input  wire       arst_n_i,
	input  wire [7:0] amp_mv_i,
	input  wire [1:0] on_code_i,
	input  wire [1:0] off_code_i,
	output reg  [7:0] on_mv_o,
	output reg  [7:0] off_mv_o,
	output reg        present_o
);
	reg [7:0] on_mv_nxt;
	reg [7:0] off_mv_nxt;
	reg       present_nxt;

	always @* begin
		case (on_code_i) // [RULE_12]
		2'h0:    on_mv_nxt = `EQC_ON_MV_00;
		2'h1:    on_mv_nxt = `EQC_ON_MV_01;
		2'h2:    on_mv_nxt = `EQC_ON_MV_10;
		default: on_mv_nxt = `EQC_ON_MV_11;
		endcase
		case (off_code_i) // [RULE_13]
		2'h0:    off_mv_nxt = `EQC_OFF_MV_00;
		2'h1:    off_mv_nxt = `EQC_OFF_MV_01;
		2'h2:    off_mv_nxt = `EQC_OFF_MV_10;
		default: off_mv_nxt = `EQC_OFF_MV_11;
		endcase
	end

	// thresholds used are the registered ones, so a code change settles in one cycle
	always @* begin
		present_nxt = present_o; // [RULE_17]
		if (amp_mv_i > on_mv_o) begin
			present_nxt = 1'b1; // [RULE_10]
		end else if (amp_mv_i < off_mv_o) begin
			present_nxt = 1'b0; // [RULE_11]
		end
	end

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			on_mv_o   <= `EQC_ON_MV_00;
			off_mv_o  <= `EQC_OFF_MV_00;
			present_o <= 1'b0;
		end else begin
			on_mv_o   <= on_mv_nxt;
			off_mv_o  <= off_mv_nxt;
			present_o <= present_nxt;
		end
	end
endmodule
`default_nettype wire

// >>> logic/eqctl_top.v
/*
 * equalizer control logic: boost source selection, active/standby state,
 * clock presence reporting and output swing selection, with the register
 * bank written and read by the management port's protocol engine.
 * assumes a byte-wide register port from that engine, synchronous inputs
 * and one clock.
 */
// Overview of operation
// RULE_01: source pin high: pin code to all
// RULE_02: source pin low: per-channel register codes
// RULE_03: unconnected source pin reads as high
// RULE_04: 3-bit boost, 000 min, 111 max
// RULE_05: source bit 0: enable pin sets state
// RULE_06: source bit 1: register bit, 0 active
// RULE_07: standby powers channels down, control stays
// RULE_08: active enables all data and clock stages; code leaves a channel off if its register disable bit is set while source bit is 1
// RULE_09: presence in status bit and pin alike
// RULE_10: presence high above on threshold
// RULE_11: presence low below off threshold
// RULE_12: on threshold code 70/55/90/75 mV
// RULE_13: off threshold code 40/30/55/45 mV
// RULE_14: one swing code for all drivers
// RULE_15: swing in bits 3:2, default 1000 mV
// RULE_16: board ties presence to enable pin
// RULE_17: hold presence between the two thresholds
`timescale 1ns/100ps
`default_nettype none
`include "eqctl_defs.vh"

module eqctl_top #(
	parameter [3:0] REVISION = `EQC_REV_DEFAULT // arbitrary value
) (
	input  wire       CLK_SYS_I,
	input  wire       ARST_N_I,
	input  wire       BOOST_SRC_PIN_I,
	input  wire       BOOST_SRC_DRIVEN_I,
	input  wire [2:0] BOOST_CODE_PINS_I,
	input  wire       ENABLE_PIN_I,
	input  wire [7:0] CLK_AMP_MV_I,
	input  wire [7:0] REG_ADDR_I,
	input  wire [7:0] REG_WDATA_I,
	input  wire       REG_WR_I,
	input  wire       REG_RD_I,
	output reg  [7:0] REG_RDATA_O,
	output wire       CLOCK_PRESENCE_O,
	output reg        DEVICE_ACTIVE_O,
	output reg  [2:0] DATA_EQ_EN_O,
	output reg  [2:0] DATA_LA_EN_O,
	output reg  [2:0] DATA_BUF_EN_O,
	output reg        CLK_LA_EN_O,
	output reg        CLK_BUF_EN_O,
	output reg  [8:0] BOOST_CODES_O,
	output reg  [1:0] SWING_CODE_O,
	output wire [7:0] ON_THR_MV_O,
	output wire [7:0] OFF_THR_MV_O
);
	// writable state
	reg       ch0_dis_r;
	reg [2:0] ch0_boost_r;
	reg       clk_dis_r;
	reg       ch2_dis_r;
	reg [2:0] ch2_boost_r;
	reg       ch1_dis_r;
	reg [2:0] ch1_boost_r;
	reg [1:0] on_code_r;
	reg [1:0] off_code_r;
	reg       en_src_r;
	reg [1:0] swing_r;

	// next values of the writable state
	reg       ch0_dis_nxt;
	reg [2:0] ch0_boost_nxt;
	reg       clk_dis_nxt;
	reg       ch2_dis_nxt;
	reg [2:0] ch2_boost_nxt;
	reg       ch1_dis_nxt;
	reg [2:0] ch1_boost_nxt;
	reg [1:0] on_code_nxt;
	reg [1:0] off_code_nxt;
	reg       en_src_nxt;
	reg [1:0] swing_nxt;

	// reset images of the two boost registers, split into their fields below
	localparam [7:0] RST_BOOST_A = `EQC_RST_BOOST_A;
	localparam [7:0] RST_BOOST_B = `EQC_RST_BOOST_B;

	wire       presence;
	wire       boost_src;
	wire [8:0] reg_boost;
	wire [2:0] chan_dis;
	reg        active_nxt;
	reg  [7:0] rdata_nxt;
	wire [8:0] boost_nxt;
	wire [2:0] data_en_nxt;
	reg        clk_en_nxt;

	// floating pin is seen as high, as the internal pull-up would make it
	assign boost_src = BOOST_SRC_DRIVEN_I ? BOOST_SRC_PIN_I : 1'b1; // [RULE_03]

	assign reg_boost = {ch2_boost_r, ch1_boost_r, ch0_boost_r};
	assign chan_dis  = {ch2_dis_r, ch1_dis_r, ch0_dis_r};

	// register writes; status offsets and unmapped offsets ignore writes
	always @* begin
		ch0_dis_nxt   = ch0_dis_r;
		ch0_boost_nxt = ch0_boost_r;
		clk_dis_nxt   = clk_dis_r;
		ch2_dis_nxt   = ch2_dis_r;
		ch2_boost_nxt = ch2_boost_r;
		ch1_dis_nxt   = ch1_dis_r;
		ch1_boost_nxt = ch1_boost_r;
		on_code_nxt   = on_code_r;
		off_code_nxt  = off_code_r;
		en_src_nxt    = en_src_r;
		swing_nxt     = swing_r;
		if (REG_WR_I) begin
			case (REG_ADDR_I)
			`EQC_ADDR_BOOST_A: begin
				ch0_dis_nxt   = REG_WDATA_I[`EQC_HI_EN_BIT];
				ch0_boost_nxt = REG_WDATA_I[`EQC_HI_BOOST_MSB:`EQC_HI_BOOST_LSB]; // [RULE_04]
				clk_dis_nxt   = REG_WDATA_I[`EQC_LO_EN_BIT];
			end
			`EQC_ADDR_BOOST_B: begin
				ch2_dis_nxt   = REG_WDATA_I[`EQC_HI_EN_BIT];
				ch2_boost_nxt = REG_WDATA_I[`EQC_HI_BOOST_MSB:`EQC_HI_BOOST_LSB];
				ch1_dis_nxt   = REG_WDATA_I[`EQC_LO_EN_BIT];
				ch1_boost_nxt = REG_WDATA_I[`EQC_LO_BOOST_MSB:`EQC_LO_BOOST_LSB];
			end
			`EQC_ADDR_ON_THR: begin
				on_code_nxt = REG_WDATA_I[`EQC_THR_MSB:`EQC_THR_LSB]; // [RULE_12]
			end
			`EQC_ADDR_OFF_THR: begin
				off_code_nxt = REG_WDATA_I[`EQC_THR_MSB:`EQC_THR_LSB]; // [RULE_13]
			end
			`EQC_ADDR_EN_SRC: begin
				en_src_nxt = REG_WDATA_I[`EQC_EN_SRC_BIT];
			end
			`EQC_ADDR_SWING: begin
				swing_nxt = REG_WDATA_I[`EQC_SWING_MSB:`EQC_SWING_LSB]; // [RULE_15]
			end
			default: begin
				en_src_nxt = en_src_r;
			end
			endcase
		end
	end

	// reserved bits are never stored, so they always read back as zero
	always @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			ch0_dis_r   <= RST_BOOST_A[`EQC_HI_EN_BIT];
			ch0_boost_r <= RST_BOOST_A[`EQC_HI_BOOST_MSB:`EQC_HI_BOOST_LSB];
			clk_dis_r   <= RST_BOOST_A[`EQC_LO_EN_BIT];
			ch2_dis_r   <= RST_BOOST_B[`EQC_HI_EN_BIT];
			ch2_boost_r <= RST_BOOST_B[`EQC_HI_BOOST_MSB:`EQC_HI_BOOST_LSB];
			ch1_dis_r   <= RST_BOOST_B[`EQC_LO_EN_BIT];
			ch1_boost_r <= RST_BOOST_B[`EQC_LO_BOOST_MSB:`EQC_LO_BOOST_LSB];
			on_code_r   <= `EQC_RST_THR;
			off_code_r  <= `EQC_RST_THR;
			en_src_r    <= `EQC_RST_EN_SRC;
			swing_r     <= `EQC_RST_SWING; // [RULE_15]
		end else begin
			ch0_dis_r   <= ch0_dis_nxt;
			ch0_boost_r <= ch0_boost_nxt;
			clk_dis_r   <= clk_dis_nxt;
			ch2_dis_r   <= ch2_dis_nxt;
			ch2_boost_r <= ch2_boost_nxt;
			ch1_dis_r   <= ch1_dis_nxt;
			ch1_boost_r <= ch1_boost_nxt;
			on_code_r   <= on_code_nxt;
			off_code_r  <= off_code_nxt;
			en_src_r    <= en_src_nxt;
			swing_r     <= swing_nxt;
		end
	end

	// device state
	always @* begin
		if (en_src_r) begin
			active_nxt = ~clk_dis_r; // [RULE_06]
		end else begin
			active_nxt = ENABLE_PIN_I; // [RULE_05]
		end
	end

	// boost selection, one mux per data channel
	genvar ch;
	generate
		for (ch = 0; ch < 3; ch = ch + 1) begin : g_chan
			wire [2:0] pin_code;
			wire [2:0] reg_code;
			wire       chan_off;

			// the same pin code goes to every channel
			assign pin_code = BOOST_CODE_PINS_I; // [RULE_01]
			assign reg_code = reg_boost[3*ch+2:3*ch]; // [RULE_02]
			assign boost_nxt[3*ch+2:3*ch] = boost_src ? pin_code : reg_code;
			// per-channel disable bits only count under register control
			assign chan_off = en_src_r & chan_dis[ch];
			assign data_en_nxt[ch] = active_nxt & ~chan_off; // [RULE_08]
		end
	endgenerate

	always @* begin
		clk_en_nxt = active_nxt; // [RULE_08]
	end

	// stage enables; standby drops every channel stage, registers keep running
	always @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			DEVICE_ACTIVE_O <= 1'b0;
			DATA_EQ_EN_O    <= 3'h0;
			DATA_LA_EN_O    <= 3'h0;
			DATA_BUF_EN_O   <= 3'h0;
			CLK_LA_EN_O     <= 1'b0;
			CLK_BUF_EN_O    <= 1'b0;
			BOOST_CODES_O   <= 9'h000;
			SWING_CODE_O    <= `EQC_RST_SWING;
		end else begin
			DEVICE_ACTIVE_O <= active_nxt;
			DATA_EQ_EN_O    <= data_en_nxt; // [RULE_07]
			DATA_LA_EN_O    <= data_en_nxt; // [RULE_07]
			DATA_BUF_EN_O   <= data_en_nxt;
			CLK_LA_EN_O     <= clk_en_nxt; // [RULE_07]
			CLK_BUF_EN_O    <= clk_en_nxt;
			BOOST_CODES_O   <= boost_nxt;
			SWING_CODE_O    <= swing_r; // [RULE_14]
		end
	end

	// presence detector runs in standby too
	eqctl_presence u_presence (
		.clk_i      (CLK_SYS_I),
		.arst_n_i   (ARST_N_I),
		.amp_mv_i   (CLK_AMP_MV_I),
		.on_code_i  (on_code_r),
		.off_code_i (off_code_r),
		.on_mv_o    (ON_THR_MV_O),
		.off_mv_o   (OFF_THR_MV_O),
		.present_o  (presence)
	);

	// pin and status bit come from the same flop, so they cannot disagree
	assign CLOCK_PRESENCE_O = presence; // [RULE_09]

	// read mux; reserved bits and unmapped offsets read zero
	always @* begin
		rdata_nxt = `EQC_ZERO_BYTE;
		case (REG_ADDR_I)
		`EQC_ADDR_STAT0: begin
			rdata_nxt[`EQC_REV_MSB:`EQC_REV_LSB] = REVISION;
			rdata_nxt[`EQC_PRES_BIT]             = presence; // [RULE_09]
		end
		`EQC_ADDR_STAT1: begin
			rdata_nxt[`EQC_HI_BOOST_MSB:`EQC_HI_BOOST_LSB] = BOOST_CODES_O[2:0];
			rdata_nxt[`EQC_LO_EN_BIT]                      = DEVICE_ACTIVE_O;
		end
		`EQC_ADDR_STAT2: begin
			rdata_nxt[`EQC_HI_BOOST_MSB:`EQC_HI_BOOST_LSB] = BOOST_CODES_O[8:6];
			rdata_nxt[`EQC_LO_BOOST_MSB:`EQC_LO_BOOST_LSB] = BOOST_CODES_O[5:3];
		end
		`EQC_ADDR_BOOST_A: begin
			rdata_nxt[`EQC_HI_EN_BIT]                      = ch0_dis_r;
			rdata_nxt[`EQC_HI_BOOST_MSB:`EQC_HI_BOOST_LSB] = ch0_boost_r;
			rdata_nxt[`EQC_LO_EN_BIT]                      = clk_dis_r;
		end
		`EQC_ADDR_BOOST_B: begin
			rdata_nxt[`EQC_HI_EN_BIT]                      = ch2_dis_r;
			rdata_nxt[`EQC_HI_BOOST_MSB:`EQC_HI_BOOST_LSB] = ch2_boost_r;
			rdata_nxt[`EQC_LO_EN_BIT]                      = ch1_dis_r;
			rdata_nxt[`EQC_LO_BOOST_MSB:`EQC_LO_BOOST_LSB] = ch1_boost_r;
		end
		`EQC_ADDR_ON_THR: begin
			rdata_nxt[`EQC_THR_MSB:`EQC_THR_LSB] = on_code_r;
		end
		`EQC_ADDR_OFF_THR: begin
			rdata_nxt[`EQC_THR_MSB:`EQC_THR_LSB] = off_code_r;
		end
		`EQC_ADDR_EN_SRC: begin
			rdata_nxt[`EQC_EN_SRC_BIT] = en_src_r; // [RULE_16]
		end
		`EQC_ADDR_SWING: begin
			rdata_nxt[`EQC_SWING_MSB:`EQC_SWING_LSB] = swing_r;
		end
		default: begin
			rdata_nxt = `EQC_ZERO_BYTE;
		end
		endcase
	end

	// read data is held until the next read strobe
	always @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			REG_RDATA_O <= `EQC_ZERO_BYTE;
		end else if (REG_RD_I) begin
			REG_RDATA_O <= rdata_nxt;
		end
	end
endmodule
`default_nettype wire

// >>> testbench/eqctl_board.sv
/* board model: enable pin from the host or tied to the presence pin.
   assumes the tie is plain wiring with no delay. */
`timescale 1ns/100ps
`default_nettype none
module eqctl_board (
	input  wire logic auto_i,
	input  wire logic presence_i,
	input  wire logic host_en_i,
	output logic      en_pin_o
);
	assign en_pin_o = auto_i ? presence_i : host_en_i;
endmodule
`default_nettype wire

// >>> testbench/eqctl_props.sv
/* assertions on eqctl_top ports.
   assumes one clock and the register write timing of the port. */
`timescale 1ns/100ps
`default_nettype none
module eqctl_props (
	input wire logic       CLK_SYS_I,
	input wire logic       ARST_N_I,
	input wire logic       BOOST_SRC_PIN_I,
	input wire logic       BOOST_SRC_DRIVEN_I,
	input wire logic [2:0] BOOST_CODE_PINS_I,
	input wire logic       ENABLE_PIN_I,
	input wire logic [7:0] CLK_AMP_MV_I,
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [7:0] REG_WDATA_I,
	input wire logic       REG_WR_I,
	input wire logic       REG_RD_I,
	input wire logic [7:0] REG_RDATA_O,
	input wire logic       CLOCK_PRESENCE_O,
	input wire logic       DEVICE_ACTIVE_O,
	input wire logic [2:0] DATA_EQ_EN_O,
	input wire logic       CLK_LA_EN_O,
	input wire logic [8:0] BOOST_CODES_O,
	input wire logic [1:0] SWING_CODE_O,
	input wire logic [7:0] ON_THR_MV_O,
	input wire logic [7:0] OFF_THR_MV_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!ARST_N_I);
	// shadow copies of the control registers, seen only through writes
	logic       src_r;
	logic       en_r;
	logic [1:0] on_r;
	logic [1:0] off_r;
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			src_r <= 1'b0;
			en_r  <= 1'b0;
			on_r  <= 2'h0;
			off_r <= 2'h0;
		end else if (REG_WR_I) begin
			if (REG_ADDR_I == 8'h07) src_r <= REG_WDATA_I[0];
			if (REG_ADDR_I == 8'h03) en_r <= REG_WDATA_I[3];
			if (REG_ADDR_I == 8'h05) on_r <= REG_WDATA_I[1:0];
			if (REG_ADDR_I == 8'h06) off_r <= REG_WDATA_I[1:0];
		end
	end
	wire       exp_act = src_r ? !en_r : ENABLE_PIN_I;
	wire [7:0] on_exp  = on_r == 2'h0 ? 8'h46 : on_r == 2'h1 ? 8'h37 : on_r == 2'h2 ? 8'h5A : 8'h4B;
	wire [7:0] off_exp = off_r == 2'h0 ? 8'h28 : off_r == 2'h1 ? 8'h1E : off_r == 2'h2 ? 8'h37 : 8'h2D;
	sequence s_sw_wr;
		REG_WR_I && REG_ADDR_I == 8'h08;
	endsequence
	sequence s_between;
		CLK_AMP_MV_I >= OFF_THR_MV_O && CLK_AMP_MV_I <= ON_THR_MV_O;
	endsequence
	property p_swing;
		s_sw_wr |=> ##1 SWING_CODE_O == $past(REG_WDATA_I[3:2], 2);
	endproperty
	a_swing: assert property (p_swing) else $error("swing code not applied");
	property p_stby;
		!DEVICE_ACTIVE_O |-> DATA_EQ_EN_O == 3'h0 && !CLK_LA_EN_O;
	endproperty
	a_stby: assert property (p_stby) else $error("stage enabled in standby");
	property p_act;
		DEVICE_ACTIVE_O && !$past(src_r) |-> DATA_EQ_EN_O == 3'h7 && CLK_LA_EN_O;
	endproperty
	a_act: assert property (p_act) else $error("stage off while active");
	property p_state;
		ARST_N_I |=> DEVICE_ACTIVE_O == $past(exp_act);
	endproperty
	a_state: assert property (p_state) else $error("device state wrong");
	property p_pin;
		ARST_N_I && (BOOST_SRC_PIN_I || !BOOST_SRC_DRIVEN_I) |=> BOOST_CODES_O == {3{$past(BOOST_CODE_PINS_I)}};
	endproperty
	a_pin: assert property (p_pin) else $error("pin boost not shared");
	property p_on;
		CLK_AMP_MV_I > ON_THR_MV_O |=> CLOCK_PRESENCE_O;
	endproperty
	a_on: assert property (p_on) else $error("presence not set");
	property p_off;
		CLK_AMP_MV_I < OFF_THR_MV_O |=> !CLOCK_PRESENCE_O;
	endproperty
	a_off: assert property (p_off) else $error("presence not cleared");
	property p_hold;
		s_between |=> $stable(CLOCK_PRESENCE_O);
	endproperty
	a_hold: assert property (p_hold) else $error("presence moved between thresholds");
	property p_thr;
		ARST_N_I |=> ON_THR_MV_O == $past(on_exp) && OFF_THR_MV_O == $past(off_exp);
	endproperty
	a_thr: assert property (p_thr) else $error("threshold map wrong");
	property p_stat;
		REG_RD_I && REG_ADDR_I == 8'h00 |=> REG_RDATA_O[0] == $past(CLOCK_PRESENCE_O);
	endproperty
	a_stat: assert property (p_stat) else $error("status bit differs from pin");
endmodule
bind eqctl_top eqctl_props props (.CLK_SYS_I, .ARST_N_I, .BOOST_SRC_PIN_I, .BOOST_SRC_DRIVEN_I,
	.BOOST_CODE_PINS_I, .ENABLE_PIN_I, .CLK_AMP_MV_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .REG_RD_I,
	.REG_RDATA_O, .CLOCK_PRESENCE_O, .DEVICE_ACTIVE_O, .DATA_EQ_EN_O, .CLK_LA_EN_O, .BOOST_CODES_O,
	.SWING_CODE_O, .ON_THR_MV_O, .OFF_THR_MV_O);
`default_nettype wire

// >>> testbench/tb_equalizer_control_logic.sv
/* self-checking bench of eqctl_top with the board model.
   assumes eqctl_props is bound to the design. */
`timescale 1ns/100ps
`default_nettype none
module tb_equalizer_control_logic;
	logic       CLK_SYS_I = 0;
	logic       ARST_N_I = 0;
	logic       BOOST_SRC_PIN_I = 1;
	logic       BOOST_SRC_DRIVEN_I = 1;
	logic [2:0] BOOST_CODE_PINS_I = 0;
	logic [7:0] CLK_AMP_MV_I = 0;
	logic [7:0] REG_ADDR_I = 0;
	logic [7:0] REG_WDATA_I = 0;
	logic       REG_WR_I = 0;
	logic       REG_RD_I = 0;
	logic       auto_en = 0;
	logic       host_en = 1;
	logic       pe = 0;
	logic       e;
	logic [7:0] d, a3, a4;
	logic [7:0] rv [0:6] = '{8'h70, 8'h77, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00};
	integer     seed = 32'h8fa812b3;
	integer     error_cnt = 0;
	integer     check_count = 0;
	integer     i, j;
	wire        ENABLE_PIN_I, CLOCK_PRESENCE_O, DEVICE_ACTIVE_O, CLK_LA_EN_O, CLK_BUF_EN_O;
	wire  [7:0] REG_RDATA_O, ON_THR_MV_O, OFF_THR_MV_O;
	wire  [2:0] DATA_EQ_EN_O, DATA_LA_EN_O, DATA_BUF_EN_O;
	wire  [8:0] BOOST_CODES_O;
	wire  [1:0] SWING_CODE_O;

	always #10 CLK_SYS_I = ~CLK_SYS_I;

	eqctl_top DUT (.CLK_SYS_I, .ARST_N_I, .BOOST_SRC_PIN_I, .BOOST_SRC_DRIVEN_I, .BOOST_CODE_PINS_I,
		.ENABLE_PIN_I, .CLK_AMP_MV_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .REG_RD_I, .REG_RDATA_O,
		.CLOCK_PRESENCE_O, .DEVICE_ACTIVE_O, .DATA_EQ_EN_O, .DATA_LA_EN_O, .DATA_BUF_EN_O,
		.CLK_LA_EN_O, .CLK_BUF_EN_O, .BOOST_CODES_O, .SWING_CODE_O, .ON_THR_MV_O, .OFF_THR_MV_O);
	eqctl_board board (.auto_i(auto_en), .presence_i(CLOCK_PRESENCE_O), .host_en_i(host_en),
		.en_pin_o(ENABLE_PIN_I));

	task chk(input [8:0] got, input [8:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input [7:0] a, input [7:0] v);
		@(posedge CLK_SYS_I);
		REG_ADDR_I <= a;
		REG_WDATA_I <= v;
		REG_WR_I <= 1;
		@(posedge CLK_SYS_I);
		REG_WR_I <= 0;
	endtask
	task rd(input [7:0] a, output [7:0] v);
		@(posedge CLK_SYS_I);
		REG_ADDR_I <= a;
		REG_RD_I <= 1;
		@(posedge CLK_SYS_I);
		REG_RD_I <= 0;
		#1 v = REG_RDATA_O;
	endtask
	// two edges: register edge plus the registered output stage
	task settle;
		repeat (2) @(posedge CLK_SYS_I);
		#1;
	endtask
	function [7:0] thr(input on, input [1:0] c);
		if (on) thr = c == 0 ? 8'h46 : c == 1 ? 8'h37 : c == 2 ? 8'h5A : 8'h4B;
		else thr = c == 0 ? 8'h28 : c == 1 ? 8'h1E : c == 2 ? 8'h37 : 8'h2D;
	endfunction
	task close_out;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		#1000000;
		error_cnt++;
		close_out;
	end

	initial begin
		repeat (10) @(posedge CLK_SYS_I);
		#1 chk(SWING_CODE_O, 9'h2);
		chk(ON_THR_MV_O, 9'h46);
		chk(OFF_THR_MV_O, 9'h28);
		@(posedge CLK_SYS_I) ARST_N_I <= 1;
		for (i = 3; i < 10; i++) begin
			rd(i[7:0], d);
			chk(d, rv[i-3]);
		end
		// upper half leaves the select pin open, which must act as high
		for (i = 0; i < 16; i++) begin
			@(posedge CLK_SYS_I);
			BOOST_CODE_PINS_I <= i[2:0];
			BOOST_SRC_DRIVEN_I <= !i[3];
			BOOST_SRC_PIN_I <= !i[3];
			settle;
			chk(BOOST_CODES_O, {3{i[2:0]}});
		end
		@(posedge CLK_SYS_I);
		BOOST_SRC_PIN_I <= 0;
		BOOST_SRC_DRIVEN_I <= 1;
		for (i = 0; i < 6; i++) begin
			a3 = $random(seed);
			a4 = $random(seed);
			wr(8'h03, a3);
			wr(8'h04, a4);
			settle;
			chk(BOOST_CODES_O, {a4[6:4], a4[2:0], a3[6:4]});
			rd(8'h01, d);
			chk(d, {1'b0, a3[6:4], 1'b1, 3'h0});
			rd(8'h02, d);
			chk(d, {1'b0, a4[6:4], 1'b0, a4[2:0]});
		end
		wr(8'h04, 8'h77);
		for (i = 0; i < 8; i++) begin
			@(posedge CLK_SYS_I) host_en <= i[0];
			wr(8'h07, {7'h0, i[2]});
			wr(8'h03, {4'h7, i[1], 3'h7});
			settle;
			e = i[2] ? !i[1] : i[0];
			chk(DEVICE_ACTIVE_O, e);
			chk({CLK_LA_EN_O, CLK_BUF_EN_O, DATA_EQ_EN_O, DATA_LA_EN_O}, {8{e}});
			chk(DATA_BUF_EN_O, {3{e}});
		end
		// register control still on: ch0 and ch1 disabled, ch2 and clock stay up
		wr(8'h03, 8'hF0);
		wr(8'h04, 8'h7F);
		settle;
		chk({CLK_LA_EN_O, DATA_EQ_EN_O, DATA_LA_EN_O}, {1'b1, 3'h4, 3'h4});
		chk(DATA_BUF_EN_O, 3'h4);
		wr(8'h07, 8'h00);
		for (i = 0; i < 16; i++) begin
			// start from silence so the flag has a known value before codes move
			@(posedge CLK_SYS_I) CLK_AMP_MV_I <= 0;
			pe = 0;
			wr(8'h05, {6'h0, i[1:0]});
			wr(8'h06, {6'h0, i[3:2]});
			settle;
			chk(ON_THR_MV_O, thr(1, i[1:0]));
			chk(OFF_THR_MV_O, thr(0, i[3:2]));
			for (j = 0; j < 12; j++) begin
				d = 8'({$random(seed)} % 110);
				@(posedge CLK_SYS_I) CLK_AMP_MV_I <= d;
				if (d > thr(1, i[1:0])) pe = 1;
				else if (d < thr(0, i[3:2])) pe = 0;
				@(posedge CLK_SYS_I);
				#1 chk(CLOCK_PRESENCE_O, pe);
			end
			rd(8'h00, d);
			chk(d[0], pe);
		end
		for (i = 0; i < 4; i++) begin
			wr(8'h08, {4'h0, i[1:0], 2'h0});
			settle;
			chk(SWING_CODE_O, i[1:0]);
			rd(8'h08, d);
			chk(d, {4'h0, i[1:0], 2'h0});
		end
		@(posedge CLK_SYS_I) auto_en <= 1;
		for (i = 0; i < 4; i++) begin
			@(posedge CLK_SYS_I) CLK_AMP_MV_I <= i[0] ? 8'h64 : 8'h0A;
			repeat (3) @(posedge CLK_SYS_I);
			#1 chk(DEVICE_ACTIVE_O, i[0]);
		end
		close_out;
	end
endmodule
`default_nettype wire
